// *** hw/mode_pin_config_control.sv ***
// Purpose: Mode of operation and pin configuration word with its pin behaviour
// Assumes: SPI core presents decoded word accesses on the core clock
// Notes: Watchdog period counting sits outside; this block restarts and reacts to it
// How it works
// R1: Action 00 timeout flags and lowers flag pin
// R2: Action 01 pulses supply pin, enters standby
// R3: Action 10 pulses enabled watchdog pin; 11 reserved
// R4: Every timeout sets the watchdog flag
// R5: Pin function 00 output, 10 trigger input
// R6: Fail-safe enable bit, power-up unaffected
// R7: Output source select drives pin active low
// R8: Serial fault source follows unmasked error flag
// R9: Undervoltage source ORs unmasked faults, thermal
// R10: Disable bit releases the supply control pin
// R11: Wake request pin mirrors supply or interrupts
// R12: Mode field codes sleep, standby, normal
// R13: Mode write requests; read shows actual mode
// R14: Normal entry clears init, exit sets it
// R15: Host writes one to bit five
// R16: Soft reset bit restores defaults, self clears
// R17: Wake from sleep starts four-minute guard
// R18: Disable skips guard only for sleep wakes
// R19: Test mapping picks transceiver or controller lines
// R20: Wake request pin push-pull or open drain
// R21: Rail select bit chooses internal or io
// R22: Service bit restarts watchdog, self clears
// R23: Reserved action only sets the flag
`timescale 1ns/1ps
module mode_pin_config_control
   import mode_cfg_pkg::*;
#(
   parameter logic [35:0] PULSE_LEN = PULSE_CYCLES,
   parameter logic [35:0] SWE_LEN = SWE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   // Word access from the SPI core
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [15:0] acc_addr,
   input wire logic [31:0] acc_wdata,
   output logic [31:0] acc_rdata_q,
   output logic acc_rvalid_q,
   // Any SPI transaction seen by the SPI core
   input wire logic spi_activity,
   // Watchdog timer interface
   input wire logic timeout_event,
   input wire logic timeout_flag_clear,
   output logic timeout_flag_q,
   output logic timeout_restart_q,
   output logic timeout_monitor_enable_q,
   input wire logic watchdog_out_enable,
   output logic watchdog_out_pin_q,
   // Interrupt and fault sources
   input wire fault_t faults,
   input wire fault_t fault_masks,
   input wire logic controller_interrupt_line_one,
   input wire logic wake_request_irq,
   input wire logic wake_event,
   // General purpose pin
   input wire logic general_purpose_pin_i,
   output pin_drive_t general_purpose_pin_q,
   // Supply control and wake request pins
   output pin_drive_t wake_supply_control_pin_q,
   output pin_drive_t wake_request_pin_q,
   // Mode and controller init
   output logic [1:0] op_mode_q,
   output logic controller_init_wr_q,
   output logic controller_init_bit_q,
   output logic fail_safe_enable_q,
   output logic device_soft_reset_q,
   // Test mode pin mapping
   input wire logic phy_tx,
   input wire logic phy_rx,
   input wire logic phy_en,
   input wire logic ctl_tx,
   input wire logic ctl_rx,
   output logic test_mode_enable_q,
   output logic test_tx_pin_q,
   output logic test_rx_pin_q,
   output logic test_en_pin_q
);
   // Stored configuration bits
   logic [31:0] cfg_q;
   logic [31:0] cfg_d;
   // Requested mode, not readable
   logic [1:0] mode_req_q;
   // Actual mode
   op_mode_t mode_q;
   op_mode_t mode_d;
   // Pulse counters for supply pin and watchdog pin
   logic [35:0] sup_cnt_q;
   logic [35:0] wdo_cnt_q;
   // Sleep wake guard counter and its run flag
   logic [35:0] swe_cnt_q;
   logic swe_run_q;
   // Synchroniser for the general pin input
   logic [2:0] gp_sync_q;
   logic gp_state_q;

   // Access decode
   wire cfg_hit = acc_valid && acc_addr == CFG_ADDR;
   wire cfg_wr = cfg_hit && acc_write;
   wire cfg_rd = cfg_hit && !acc_write;
   // R16: soft reset request
   wire soft_reset = cfg_wr && acc_wdata[SOFT_RESET_BIT];
   // R22: service write
   wire service_wr = cfg_wr && acc_wdata[SERVICE_BIT];

   // Field views
   wire [1:0] action = cfg_q[ACTION_LSB +: 2];
   wire [1:0] pin_func = cfg_q[PIN_FUNC_LSB +: 2];
   wire [1:0] src_sel = cfg_q[SOURCE_LSB +: 2];
   wire supply_dis = cfg_q[SUPPLY_DIS_BIT];
   wire wkrq_func = cfg_q[WKRQ_FUNC_BIT];
   wire rail_io = cfg_q[RAIL_BIT];
   wire guard_off = cfg_q[GUARD_OFF_BIT];
   wire test_map = cfg_q[TEST_MAP_BIT];

   // Code of the actual mode
   wire [1:0] mode_code = (mode_q == ST_SLEEP) ? MODE_SLEEP :
                          (mode_q == ST_NORMAL) ? MODE_NORMAL : MODE_STANDBY;
   // R13: read image shows actual mode, bit five fixed high
   wire [31:0] read_image = (cfg_q & CFG_RW_MASK) | CFG_ONE_MASK | {24'h000000, mode_code, 6'h00};

   // Timeout consequences
   // R2: supply pulse on action 01
   wire start_sup = timeout_event && action == ACT_SUPPLY;
   // R3: watchdog pin pulse on action 10 when enabled
   wire start_wdo = timeout_event && action == ACT_OUTPIN && watchdog_out_enable;
   wire sup_pulsing = sup_cnt_q != 36'h000000000;
   wire wdo_pulsing = wdo_cnt_q != 36'h000000000;

   // Synchronised general pin level; change counts once stages agree
   wire gp_agree = gp_sync_q[1] == gp_sync_q[2];
   // R5: input mode acts as watchdog trigger
   wire gp_trigger = pin_func == PIN_INPUT && gp_agree && gp_sync_q[2] != gp_state_q;

   // R8 R9: interrupt sources before active-low inversion
   wire [4:0] live = faults & ~fault_masks;
   // R8: serial fault follows unmasked flag
   wire src_serial = live[4];
   // R9: OR of unmasked undervoltage and thermal faults
   wire src_uvth = |live[3:0];
   // R7: source select, reserved code keeps pin idle high
   wire gp_src = (src_sel == SRC_SERIAL) ? src_serial :
                 (src_sel == SRC_CTRL) ? controller_interrupt_line_one :
                 (src_sel == SRC_UVTH) ? src_uvth : 1'b0;

   // Supply control level: high outside sleep, low during a pulse
   wire sup_level = mode_q != ST_SLEEP && !sup_pulsing;
   // R11: wake request pin asserted (low) source
   wire wkrq_assert = wkrq_func ? wake_request_irq : sup_level;
   // Sleep wake guard expiry and SPI activity
   wire host_seen = spi_activity || acc_valid;
   // Wake event while asleep; a host write leaving sleep is not a wake
   wire sleep_wake = mode_q == ST_SLEEP && wake_event;
   wire swe_expire = swe_run_q && swe_cnt_q == 36'h000000001 && !host_seen;

   // Next configuration word
   always_comb begin
      cfg_d = cfg_q;
      if (cfg_wr) begin
         // R15: bit five is fixed, write value ignored
         cfg_d = acc_wdata & CFG_RW_MASK;
      end
   end

   // Next actual mode
   always_comb begin
      mode_d = mode_q;
      // R12: requested mode applied, reserved request ignored
      unique case (mode_req_q)
         MODE_SLEEP: mode_d = ST_SLEEP;
         MODE_STANDBY: mode_d = ST_STANDBY;
         MODE_NORMAL: mode_d = ST_NORMAL;
         default: mode_d = mode_q;
      endcase
      if (sleep_wake) begin
         // Wake leaves sleep for standby
         mode_d = ST_STANDBY;
      end
      if (start_sup) begin
         // R2: timeout action forces standby
         mode_d = ST_STANDBY;
      end
      if (swe_expire) begin
         // R17: guard expiry returns to sleep
         mode_d = ST_SLEEP;
      end
      if (soft_reset) begin
         // R16: soft reset lands in standby, init write follows only when leaving normal
         mode_d = ST_STANDBY;
      end
   end

   // Configuration word and mode request
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q <= CFG_RESET & CFG_RW_MASK;
         mode_req_q <= CFG_RESET[MODE_LSB +: 2];
      // R16: soft reset restores defaults
      end else if (soft_reset) begin
         cfg_q <= CFG_RESET & CFG_RW_MASK;
         mode_req_q <= CFG_RESET[MODE_LSB +: 2];
      end else begin
         cfg_q <= cfg_d;
         // Forced mode changes also become the standing request
         mode_req_q <= cfg_wr ? acc_wdata[MODE_LSB +: 2] :
                       (mode_d != mode_q && !cfg_wr) ? ((mode_d == ST_SLEEP) ? MODE_SLEEP :
                       (mode_d == ST_NORMAL) ? MODE_NORMAL : MODE_STANDBY) : mode_req_q;
      end
   end

   // Actual mode and controller init writes
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= ST_STANDBY;
         controller_init_wr_q <= 1'b0;
         controller_init_bit_q <= 1'b1;
      end else begin
         mode_q <= soft_reset ? ST_STANDBY : mode_d;
         // R14: automatic init write on normal entry or exit
         controller_init_wr_q <= (mode_d == ST_NORMAL) != (mode_q == ST_NORMAL);
         if ((mode_d == ST_NORMAL) != (mode_q == ST_NORMAL)) begin
            controller_init_bit_q <= mode_d != ST_NORMAL;
         end
      end
   end

   // Pulse counters for timeout actions
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sup_cnt_q <= 36'h000000000;
         wdo_cnt_q <= 36'h000000000;
      end else begin
         // R2: supply pin low for the pulse time
         sup_cnt_q <= start_sup ? PULSE_LEN : (sup_pulsing ? sup_cnt_q - 36'h000000001 : sup_cnt_q);
         // R3 R23: watchdog pin pulse, none for reserved code
         wdo_cnt_q <= start_wdo ? PULSE_LEN : (wdo_pulsing ? wdo_cnt_q - 36'h000000001 : wdo_cnt_q);
      end
   end

   // Sleep wake guard timer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         // R18: guard runs after power-on reset
         swe_run_q <= 1'b1;
         swe_cnt_q <= SWE_CYCLES;
      end else if (host_seen || swe_expire) begin
         // R17: SPI access stops the guard
         swe_run_q <= 1'b0;
         swe_cnt_q <= 36'h000000000;
      // R18: disable only affects wakes from sleep
      end else if (sleep_wake && !guard_off) begin
         swe_run_q <= 1'b1;
         swe_cnt_q <= SWE_LEN;
      end else if (swe_run_q) begin
         swe_cnt_q <= swe_cnt_q - 36'h000000001;
      end
   end

   // Watchdog flag, restart and general pin trigger
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         timeout_flag_q <= 1'b0;
         timeout_restart_q <= 1'b0;
         gp_sync_q <= 3'b111;
         gp_state_q <= 1'b1;
      end else begin
         // R4: every timeout sets the flag; set beats clear
         timeout_flag_q <= timeout_event || (timeout_flag_q && !timeout_flag_clear);
         // R22: service write or pin trigger restarts the timer
         timeout_restart_q <= service_wr || gp_trigger;
         gp_sync_q <= {gp_sync_q[1:0], general_purpose_pin_i};
         if (gp_agree) begin
            gp_state_q <= gp_sync_q[2];
         end
      end
   end

   // Pin drivers and plain control outputs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         general_purpose_pin_q <= '{level: 1'b1, oe_n: 1'b1};
         wake_supply_control_pin_q <= '{level: 1'b1, oe_n: 1'b0};
         wake_request_pin_q <= '{level: 1'b0, oe_n: 1'b0};
         watchdog_out_pin_q <= 1'b1;
         timeout_monitor_enable_q <= 1'b1;
         fail_safe_enable_q <= 1'b0;
         device_soft_reset_q <= 1'b0;
      end else begin
         // R5 R7: output mode drives selected source active low
         general_purpose_pin_q.level <= !gp_src;
         general_purpose_pin_q.oe_n <= pin_func != PIN_OUTPUT;
         // R10: disable bit releases the pin
         wake_supply_control_pin_q.level <= sup_level;
         wake_supply_control_pin_q.oe_n <= supply_dis;
         // R20 R21: push-pull on internal rail, open drain on io rail
         wake_request_pin_q.level <= rail_io ? 1'b0 : !wkrq_assert;
         wake_request_pin_q.oe_n <= rail_io ? !wkrq_assert : 1'b0;
         // R1 R3: watchdog pin low on flag or during pulse
         watchdog_out_pin_q <= !(wdo_pulsing || (action == ACT_FLAG && timeout_flag_q));
         timeout_monitor_enable_q <= cfg_q[MONITOR_EN_BIT];
         // R6: fail-safe enable level
         fail_safe_enable_q <= cfg_q[FAIL_SAFE_BIT];
         device_soft_reset_q <= soft_reset;
      end
   end

   // Read data, mode code and test mapping
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_rdata_q <= 32'h00000000;
         acc_rvalid_q <= 1'b0;
         op_mode_q <= MODE_STANDBY;
         test_mode_enable_q <= 1'b0;
         test_tx_pin_q <= 1'b1;
         test_rx_pin_q <= 1'b1;
         test_en_pin_q <= 1'b0;
      end else begin
         acc_rdata_q <= cfg_rd ? read_image : 32'h00000000;
         acc_rvalid_q <= cfg_rd;
         op_mode_q <= mode_code;
         test_mode_enable_q <= cfg_q[TEST_EN_BIT];
         // R19: route transceiver or controller lines
         test_tx_pin_q <= test_map ? ctl_tx : phy_tx;
         test_rx_pin_q <= test_map ? ctl_rx : phy_rx;
         test_en_pin_q <= test_map ? 1'b0 : phy_en;
      end
   end
endmodule

// *** hw/mode_cfg_pkg.sv ***
// Purpose: Shared constants and types for the mode and pin configuration block
// Assumes: 250 MHz core clock, one 32-bit configuration word
// Notes: Field positions and reset values of the configuration word live here
package mode_cfg_pkg;
   // Word address of the configuration register
   localparam logic [15:0] CFG_ADDR = 16'h0800;
   // Reset image of the whole word
   localparam logic [31:0] CFG_RESET = 32'hc8000468;
   // Bits that software may write and read back as stored
   localparam logic [31:0] CFG_RW_MASK = 32'hf8ebef0b;
   // Bit that always reads back as one
   localparam logic [31:0] CFG_ONE_MASK = 32'h00000020;
   // Field positions
   localparam int ACTION_LSB = 16;
   localparam int SERVICE_BIT = 18;
   localparam int RAIL_BIT = 19;
   localparam int TEST_EN_BIT = 21;
   localparam int PIN_FUNC_LSB = 14;
   localparam int FAIL_SAFE_BIT = 13;
   localparam int SOURCE_LSB = 10;
   localparam int SUPPLY_DIS_BIT = 9;
   localparam int WKRQ_FUNC_BIT = 8;
   localparam int MODE_LSB = 6;
   localparam int MONITOR_EN_BIT = 3;
   localparam int SOFT_RESET_BIT = 2;
   localparam int GUARD_OFF_BIT = 1;
   localparam int TEST_MAP_BIT = 0;
   // Two-bit codes
   localparam logic [1:0] ACT_FLAG = 2'b00;
   localparam logic [1:0] ACT_SUPPLY = 2'b01;
   localparam logic [1:0] ACT_OUTPIN = 2'b10;
   localparam logic [1:0] PIN_OUTPUT = 2'b00;
   localparam logic [1:0] PIN_INPUT = 2'b10;
   localparam logic [1:0] SRC_SERIAL = 2'b00;
   localparam logic [1:0] SRC_CTRL = 2'b01;
   localparam logic [1:0] SRC_UVTH = 2'b10;
   localparam logic [1:0] MODE_SLEEP = 2'b00;
   localparam logic [1:0] MODE_STANDBY = 2'b01;
   localparam logic [1:0] MODE_NORMAL = 2'b10;
   // Timing
   localparam longint unsigned CLK_HZ = 250000000;
   localparam longint unsigned PULSE_TIME_MS = 300;
   localparam longint unsigned SWE_TIME_S = 240;
   localparam logic [35:0] PULSE_CYCLES = 36'(PULSE_TIME_MS * CLK_HZ / 1000);
   localparam logic [35:0] SWE_CYCLES = 36'(SWE_TIME_S * CLK_HZ);
   // Actual operating mode
   typedef enum logic [1:0] {ST_SLEEP, ST_STANDBY, ST_NORMAL} op_mode_t;
   // Fault flags and their masks
   typedef struct packed {
      logic serial_error_flag;
      logic uv_regulator;
      logic uv_supply;
      logic uv_io_supply_rail;
      logic thermal_shutdown_fault;
   } fault_t;
   // Pin driven by the block: level, and active-low output enable
   typedef struct packed {
      logic level;
      logic oe_n;
   } pin_drive_t;
endpackage

// *** dv/mode_cfg_props.sv ***
// Purpose: Port assertions for the mode and pin configuration block
// Assumes: One clock domain, reset_n asynchronous active low
// Notes: Bound to the design top at the foot of this file
`timescale 1ns/1ps
module mode_cfg_props
   import mode_cfg_pkg::*;
#(
   parameter logic [35:0] PULSE_LEN = PULSE_CYCLES,
   parameter logic [35:0] SWE_LEN = SWE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic acc_valid,
   input wire logic acc_write,
   input wire logic [15:0] acc_addr,
   input wire logic [31:0] acc_wdata,
   input wire logic [31:0] acc_rdata_q,
   input wire logic acc_rvalid_q,
   input wire logic timeout_event,
   input wire logic timeout_flag_q,
   input wire logic timeout_restart_q,
   input wire pin_drive_t wake_supply_control_pin_q,
   input wire logic [1:0] op_mode_q,
   input wire logic controller_init_wr_q,
   input wire logic controller_init_bit_q,
   input wire logic device_soft_reset_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Accesses that hit the configuration word
   wire hit = acc_valid && acc_addr == CFG_ADDR;
   wire wr_hit = hit && acc_write;
   // Stored copy of the supply pin disable bit
   logic dis_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dis_q <= 1'b0;
      end else if (wr_hit) begin
         dis_q <= acc_wdata[SUPPLY_DIS_BIT] && !acc_wdata[SOFT_RESET_BIT];
      end
   end
   sequence s_rd;
      hit && !acc_write;
   endsequence
   sequence s_wr(int b);
      wr_hit && acc_wdata[b];
   endsequence
   property p_flag_set;
      timeout_event |=> timeout_flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("timeout did not set flag");
   property p_read_ans;
      s_rd |=> acc_rvalid_q;
   endproperty
   a_read_ans: assert property (p_read_ans) else $error("read not answered");
   property p_no_ans;
      !(hit && !acc_write) |=> !acc_rvalid_q;
   endproperty
   a_no_ans: assert property (p_no_ans) else $error("answer without read");
   property p_read_fix;
      acc_rvalid_q |-> acc_rdata_q[5] && !acc_rdata_q[2] && !acc_rdata_q[18];
   endproperty
   a_read_fix: assert property (p_read_fix) else $error("fixed bits wrong");
   property p_read_mode;
      acc_rvalid_q |-> acc_rdata_q[7:6] == op_mode_q;
   endproperty
   a_read_mode: assert property (p_read_mode) else $error("mode read not actual");
   property p_service;
      s_wr(SERVICE_BIT) |=> timeout_restart_q;
   endproperty
   a_service: assert property (p_service) else $error("no watchdog restart");
   property p_soft;
      s_wr(SOFT_RESET_BIT) |=> device_soft_reset_q ##1 (!device_soft_reset_q && op_mode_q == MODE_STANDBY);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset wrong");
   property p_init_clr;
      op_mode_q == MODE_NORMAL && $past(op_mode_q) != MODE_NORMAL |-> $past(controller_init_wr_q) && !controller_init_bit_q;
   endproperty
   a_init_clr: assert property (p_init_clr) else $error("init not cleared");
   property p_init_set;
      op_mode_q != MODE_NORMAL && $past(op_mode_q) == MODE_NORMAL |-> $past(controller_init_wr_q) && controller_init_bit_q;
   endproperty
   a_init_set: assert property (p_init_set) else $error("init not set");
   property p_dis;
      $rose(dis_q) |-> ##[0:3] wake_supply_control_pin_q.oe_n;
   endproperty
   a_dis: assert property (p_dis) else $error("supply pin not released");
endmodule
bind mode_pin_config_control mode_cfg_props #(.PULSE_LEN(PULSE_LEN), .SWE_LEN(SWE_LEN)) u_props (.sys_clk,
   .reset_n, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_rdata_q, .acc_rvalid_q, .timeout_event,
   .timeout_flag_q, .timeout_restart_q, .wake_supply_control_pin_q, .op_mode_q, .controller_init_wr_q,
   .controller_init_bit_q, .device_soft_reset_q);

// *** dv/host_model.sv ***
// Purpose: Host processor issuing word accesses to the block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Address and data are scrambled while no access runs
`timescale 1ns/1ps
module host_model
   import mode_cfg_pkg::*;
(
   input wire logic sys_clk,
   output logic acc_valid,
   output logic acc_write,
   output logic [15:0] acc_addr,
   output logic [31:0] acc_wdata,
   input wire logic [31:0] acc_rdata_q,
   input wire logic acc_rvalid_q
);
   initial begin
      {acc_valid, acc_write, acc_addr, acc_wdata} = {2'b00, 16'hf7ff, 32'ha5a5a5a5};
   end
   // One access; the answer is taken at the edge after the strobe
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
         output logic v);
      @(posedge sys_clk);
      #1;
      {acc_valid, acc_write, acc_addr} = {1'b1, w, a};
      acc_wdata = d | CFG_ONE_MASK;
      @(posedge sys_clk);
      #1;
      q = acc_rdata_q;
      v = acc_rvalid_q;
      {acc_valid, acc_addr, acc_wdata} = {1'b0, ~a, ~acc_wdata};
   endtask
endmodule

// *** dv/mode_pin_config_control_tb.sv ***
// Purpose: Self-checking bench for the mode and pin configuration block
// Assumes: Short pulse and guard lengths
// Notes: Accesses go through the host model
`timescale 1ns/1ps
module mode_pin_config_control_tb import mode_cfg_pkg::*; ();
   localparam logic [35:0] PL = 36'h14;
   localparam int SL = 50;
   localparam logic [31:0] B = 32'hc8000028;
   logic sys_clk, reset_n, acc_valid, acc_write, acc_rvalid_q, spi_activity, timeout_event, timeout_flag_clear;
   logic timeout_flag_q, timeout_restart_q, timeout_monitor_enable_q, watchdog_out_enable, watchdog_out_pin_q;
   logic controller_interrupt_line_one, wake_request_irq, wake_event, general_purpose_pin_i, controller_init_wr_q;
   logic controller_init_bit_q, fail_safe_enable_q, device_soft_reset_q, phy_tx, phy_rx, phy_en, ctl_tx, ctl_rx;
   logic test_mode_enable_q, test_tx_pin_q, test_rx_pin_q, test_en_pin_q, v;
   logic [15:0] acc_addr;
   logic [31:0] acc_wdata, acc_rdata_q, q;
   logic [1:0] op_mode_q, act;
   fault_t faults, fault_masks;
   pin_drive_t general_purpose_pin_q, wake_supply_control_pin_q, wake_request_pin_q;
   int fail_count = 0, comparisons = 0, cyc = 0, lw, ls;
   mode_pin_config_control #(.PULSE_LEN(PL), .SWE_LEN(36'(SL))) dut (.*);
   host_model host (.sys_clk, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_rdata_q, .acc_rvalid_q);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Cycle ceiling against hangs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [31:0] d);
      host.xfer(1'b1, CFG_ADDR, d, q, v);
   endtask
   task automatic rd();
      host.xfer(1'b0, CFG_ADDR, 32'h0, q, v);
   endtask
   task automatic w8(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      @(posedge sys_clk);
      #1 s = 1'b1;
      @(posedge sys_clk);
      #1 s = 1'b0;
   endtask
   task automatic gp(input logic [1:0] src, input fault_t f, input fault_t m, input logic ci, input logic e);
      {faults, fault_masks, controller_interrupt_line_one} = {f, m, ci};
      wr(B | {20'h0, src, 10'h0});
      w8(3);
      chk(general_purpose_pin_q, {e, 1'b0});
   endtask
   task automatic conclude();
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      {timeout_event, timeout_flag_clear, wake_event, general_purpose_pin_i, spi_activity} = 5'h0;
      {controller_interrupt_line_one, wake_request_irq, watchdog_out_enable, reset_n} = 4'b0010;
      {phy_tx, phy_rx, phy_en, ctl_tx, ctl_rx, faults, fault_masks} = {5'b10101, 10'h0};
      repeat (20) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      rd();
      chk(q, CFG_RESET);
      wr(32'hffffff7b);
      rd();
      chk(q, (32'hffffff7b & CFG_RW_MASK) | 32'h68);
      chk({timeout_monitor_enable_q, fail_safe_enable_q, test_mode_enable_q}, 3'b111);
      host.xfer(1'b1, 16'h0804, 32'h0, q, v);
      host.xfer(1'b0, 16'h0804, 32'h0, q, v);
      chk(v, 1'b0);
      wr(32'h4);
      rd();
      chk(q, CFG_RESET);
      chk(fail_safe_enable_q, 1'b0);
      wr(B | 32'h200000);
      w8(3);
      chk({test_tx_pin_q, test_rx_pin_q, test_en_pin_q}, {phy_tx, phy_rx, phy_en});
      wr(B | 32'h200001);
      w8(3);
      chk({test_tx_pin_q, test_rx_pin_q, test_en_pin_q}, {ctl_tx, ctl_rx, 1'b0});
      gp(2'h0, 5'h10, 5'h00, 1'b0, 1'b0);
      gp(2'h0, 5'h10, 5'h10, 1'b0, 1'b1);
      gp(2'h1, 5'h00, 5'h00, 1'b1, 1'b0);
      gp(2'h1, 5'h1f, 5'h00, 1'b0, 1'b1);
      gp(2'h2, 5'h01, 5'h00, 1'b0, 1'b0);
      gp(2'h2, 5'h04, 5'h04, 1'b1, 1'b1);
      gp(2'h2, 5'h08, 5'h00, 1'b0, 1'b0);
      gp(2'h3, 5'h1f, 5'h00, 1'b1, 1'b1);
      wr(B | 32'h8000);
      w8(3);
      chk(general_purpose_pin_q.oe_n, 1'b1);
      general_purpose_pin_i = 1'b1;
      v = 1'b0;
      repeat (10) begin
         w8(1);
         v |= timeout_restart_q;
      end
      chk(v, 1'b1);
      wr(B | 32'h40000);
      chk(timeout_restart_q, 1'b1);
      wr(B | 32'h40);
      w8(3);
      chk(wake_supply_control_pin_q, 2'b10);
      chk(wake_request_pin_q, 2'b00);
      wr(B | 32'h200);
      w8(3);
      chk(wake_supply_control_pin_q.oe_n, 1'b1);
      wr(B | 32'h80100);
      w8(3);
      chk(wake_request_pin_q.oe_n, 1'b1);
      wake_request_irq = 1'b1;
      w8(3);
      chk(wake_request_pin_q, 2'b00);
      wr(B | 32'h100);
      wake_request_irq = 1'b0;
      w8(3);
      chk(wake_request_pin_q, 2'b10);
      wr(B | 32'h80);
      w8(4);
      chk({op_mode_q, controller_init_bit_q}, {MODE_NORMAL, 1'b0});
      rd();
      chk(q[7:6], MODE_NORMAL);
      wr(B);
      w8(4);
      chk({op_mode_q, controller_init_bit_q}, {MODE_SLEEP, 1'b1});
      pulse(wake_event);
      w8(3);
      chk(op_mode_q, MODE_STANDBY);
      w8(SL + 20);
      chk(op_mode_q, MODE_SLEEP);
      pulse(wake_event);
      w8(3);
      rd();
      w8(SL + 20);
      chk(op_mode_q, MODE_STANDBY);
      wr(B | 32'h2);
      w8(4);
      pulse(wake_event);
      w8(SL + 20);
      chk(op_mode_q, MODE_STANDBY);
      wr(B | 32'hc0);
      w8(4);
      chk(op_mode_q, MODE_STANDBY);
      for (int a = 0; a < 5; a++) begin
         act = (a == 4) ? 2'b10 : 2'(a);
         watchdog_out_enable = (a != 4);
         pulse(timeout_flag_clear);
         wr(B | {14'h0, act, 16'h80});
         w8(4);
         pulse(timeout_event);
         {lw, ls} = '0;
         repeat (40) begin
            w8(1);
            lw += !watchdog_out_pin_q;
            ls += !wake_supply_control_pin_q.level;
         end
         chk(timeout_flag_q, 1'b1);
         chk(ls, (a == 1) ? 32'(PL) : 32'h0);
         chk(op_mode_q, (a == 1) ? MODE_STANDBY : MODE_NORMAL);
         if (a > 1) begin
            chk(lw, (a == 2) ? 32'(PL) : 32'h0);
         end
         if (a == 0) begin
            chk(watchdog_out_pin_q, 1'b0);
            pulse(timeout_flag_clear);
            w8(3);
            chk(watchdog_out_pin_q, 1'b1);
         end
      end
      conclude();
   end
endmodule
